// file: hdl/tcp_pkg.sv
// Constants shared by the timer capture and PWM unit.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package tcp_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_AMR  = 8'h04;
  localparam logic [7:0] OFS_BMR  = 8'h08;
  localparam logic [7:0] OFS_CTL  = 8'h0c;
  localparam logic [7:0] OFS_IMR  = 8'h18;
  localparam logic [7:0] OFS_RIS  = 8'h1c;
  localparam logic [7:0] OFS_MIS  = 8'h20;
  localparam logic [7:0] OFS_ICR  = 8'h24;
  localparam logic [7:0] OFS_AILR = 8'h28;
  localparam logic [7:0] OFS_BILR = 8'h2c;
  localparam logic [7:0] OFS_AMAT = 8'h30;
  localparam logic [7:0] OFS_BMAT = 8'h34;
  localparam logic [7:0] OFS_APR  = 8'h38;
  localparam logic [7:0] OFS_BPR  = 8'h3c;
  localparam logic [7:0] OFS_AR   = 8'h48;
  localparam logic [7:0] OFS_BR   = 8'h4c;
  // ****************************************
  // Field values and positions
  // ****************************************
  localparam logic [2:0] CFG_32    = 3'h0;
  localparam logic [2:0] CFG_RTC   = 3'h1;
  localparam int         CFG_16BIT = 2;
  localparam logic [1:0] MR_ONE    = 2'h1;
  localparam logic [1:0] MR_PER    = 2'h2;
  localparam logic [1:0] MR_CAP    = 2'h3;
  localparam int         MR_AMS    = 3;
  localparam int         MR_CMR    = 2;
  // Control: one byte per half, half B at bit 8
  localparam int         HALF_W    = 8;
  localparam int         CTL_EN    = 0;
  localparam int         CTL_STALL = 1;
  localparam int         CTL_EV    = 2;
  localparam int         CTL_RTCO  = 4;
  localparam int         CTL_INV   = 6;
  localparam logic [1:0] EV_RISE   = 2'h0;
  localparam logic [1:0] EV_FALL   = 2'h1;
  // Status and mask: one byte per half
  localparam int         FL_TO     = 0;
  localparam int         FL_CM     = 1;
  localparam int         FL_CE     = 2;
  localparam int         FL_RTC    = 3;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [15:0] LOAD_RST  = 16'hffff;
  localparam logic [31:0] RTC_START = 32'h00000001;
  localparam int          RTC_DIV   = 32768;
endpackage

// file: hdl/tcp_timer_capture_pwm_unit.sv
// Timer capture/compare/PWM unit: two 16-bit halves or one 32-bit timer.
// Assumes a classic Wishbone master and a pin signal asynchronous to clk_i.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
// Overview of operation
// - Edge count steps once per edge; edge time and PWM count every clock, no prescaler.
// - Capture type clear: count rising, falling or both edges downward.
// - Each edge decrements; on match set raw and masked match flags.
// - On match reload, clear run enable, ignore edges until re-enabled.
// - Capture type set: free down-counter from load, one edge kind only.
// - Edge time: copy counter to capture register, set event flags.
// - Edge time keeps counting; at zero reloads from load value.
// - Captured value holds until the next selected edge replaces it.
// - PWM when alt mode 1, capture type 0, mode 2; load sets period.
// - PWM counts to zero, reloads next cycle, repeats until disabled.
// - PWM mode raises no flag.
// - PWM output asserts at load value, deasserts at match value.
// - Invert bit flips PWM output polarity.
// - Config 0 is 32-bit timer, 1 is 32-bit clock, 4 is split.
// - Mode 1 one-shot stops after time-out; mode 2 periodic continues.
// - Writing one to status clear clears that raw and masked pair.
// - Clock mode: on count equal match reload zero and keep counting.
// - Clock match flag need not be cleared for counting to continue.
// - Mode 3 is capture; capture type picks edge count or edge time.
// - One-shot time-out stops and clears run enable; periodic reloads.
module tcp_timer_capture_pwm_unit #(
  parameter int RTC_DIV = tcp_pkg::RTC_DIV
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Capture/compare pins, index 0 = half A
  input  wire logic [1:0]  capture_compare_pin_i,
  output logic      [1:0]  capture_compare_pin_o,
  output logic      [1:0]  capture_compare_pin_oe_o
);
  localparam int DW = (RTC_DIV < 2) ? 1 : $clog2(RTC_DIV);
  localparam int HALF_W = tcp_pkg::HALF_W;
  if (RTC_DIV < 2) begin : g_chk
    $error("RTC_DIV must be at least 2");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Byte-lane merge of a write
  function automatic logic [31:0] bmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      bmask[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction
  // Qualifying edge for the chosen event type
  function automatic logic edge_hit(input logic [1:0] ev, input logic r, input logic f,
                                    input logic both_ok);
    if (ev == tcp_pkg::EV_RISE) begin
      edge_hit = r;
    end else if (ev == tcp_pkg::EV_FALL) begin
      edge_hit = f;
    end else begin
      edge_hit = both_ok & (r | f);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [2:0]    cfg_q;
  logic [3:0]    mr_q [2];
  logic [15:0]   ctl_q, imr_q, ris_q;
  logic [15:0]   ilr_q [2];
  logic [15:0]   mat_q [2];
  logic [15:0]   cnt_q [2];
  logic [15:0]   cnt_d [2];
  logic [15:0]   cap_q [2];
  logic [15:0]   cap_d [2];
  logic [7:0]    pr_q  [2];
  logic [7:0]    ps_q  [2];
  logic [7:0]    ps_d  [2];
  logic [1:0]    s1_q, s2_q, s3_q, pwm_q, pwm_d, pin_q, oe_q;
  logic [DW-1:0] div_q;
  logic          ack_q;
  logic [31:0]   dat_q, rd_d;
  logic [15:0]   set_v, ilr_nv [2];
  logic [1:0]    en_clr, ilr_wr, en, stl, rse, fal, hit;
  logic [1:0]    is_cnt, is_tim, is_pwm, is_tmr;
  logic          cfg16, wr, sec_tick;
  logic [31:0]   c32, i32, m32, n32;
  logic [15:0]   dec0;

  assign cfg16 = cfg_q[tcp_pkg::CFG_16BIT];
  assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign c32   = {cnt_q[1], cnt_q[0]};
  assign i32   = {ilr_q[1], ilr_q[0]};
  assign m32   = {mat_q[1], mat_q[0]};
  assign dec0  = cnt_q[0] - 16'h0001;

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  // Two flops, then a third for the edge compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
    end else begin
      s1_q <= capture_compare_pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-half mode decode and edges
  always_comb begin
    for (int h = 0; h < 2; h++) begin
      en[h]     = ctl_q[HALF_W*h + tcp_pkg::CTL_EN];
      stl[h]    = ctl_q[HALF_W*h + tcp_pkg::CTL_STALL];
      rse[h]    = s2_q[h] & ~s3_q[h];
      fal[h]    = ~s2_q[h] & s3_q[h];
      is_cnt[h] = cfg16 & (mr_q[h][1:0] == tcp_pkg::MR_CAP) & ~mr_q[h][tcp_pkg::MR_CMR];
      is_tim[h] = cfg16 & (mr_q[h][1:0] == tcp_pkg::MR_CAP) & mr_q[h][tcp_pkg::MR_CMR];
      is_pwm[h] = cfg16 & mr_q[h][tcp_pkg::MR_AMS] & ~mr_q[h][tcp_pkg::MR_CMR]
                  & (mr_q[h][1:0] == tcp_pkg::MR_PER);
      is_tmr[h] = cfg16 & ~mr_q[h][tcp_pkg::MR_AMS]
                  & ((mr_q[h][1:0] == tcp_pkg::MR_ONE) | (mr_q[h][1:0] == tcp_pkg::MR_PER));
      // Both edges allowed only when counting edges
      hit[h]    = edge_hit(ctl_q[HALF_W*h + tcp_pkg::CTL_EV +: 2], rse[h], fal[h],
                           is_cnt[h]);
    end
  end

  // ****************************************
  // Clock-mode divider
  // ****************************************
  assign sec_tick = rse[0] & (div_q == DW'(RTC_DIV - 1));
  // Half A pin rising edges divided down to one tick per second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else if ((cfg_q != tcp_pkg::CFG_RTC) | ~en[0]) begin
      div_q <= '0;
    end else if (rse[0]) begin
      div_q <= sec_tick ? '0 : div_q + DW'(1);
    end
  end

  // ****************************************
  // Counter next state and events
  // ****************************************
  always_comb begin
    set_v  = 16'h0000;
    en_clr = 2'h0;
    pwm_d  = pwm_q;
    n32    = c32;
    for (int h = 0; h < 2; h++) begin
      cnt_d[h] = cnt_q[h];
      cap_d[h] = cap_q[h];
      ps_d[h]  = ps_q[h];
    end
    if (cfg_q == tcp_pkg::CFG_32) begin
      // One 32-bit down-counter steered by half A
      if (en[0] & ~stl[0]) begin
        if (c32 == 32'h0) begin
          n32 = i32;
          set_v[tcp_pkg::FL_TO] = 1'b1;
          en_clr[0] = (mr_q[0][1:0] == tcp_pkg::MR_ONE);
        end else begin
          n32 = c32 - 32'h1;
        end
      end
    end else if (cfg_q == tcp_pkg::CFG_RTC) begin
      // 32-bit up-counter on one-second ticks
      if (en[0] & (~stl[0] | ctl_q[tcp_pkg::CTL_RTCO]) & sec_tick) begin
        if (c32 == m32) begin
          n32 = 32'h0;
          set_v[tcp_pkg::FL_RTC] = 1'b1;
        end else begin
          n32 = c32 + 32'h1;
        end
      end
    end
    if (!cfg16) begin
      cnt_d[0] = n32[15:0];
      cnt_d[1] = n32[31:16];
    end else begin
      // Halves run on their own settings
      for (int h = 0; h < 2; h++) begin
        if (en[h] & is_cnt[h]) begin
          if (hit[h]) begin
            if (cnt_q[h] - 16'h0001 == mat_q[h]) begin
              cnt_d[h] = ilr_q[h];
              en_clr[h] = 1'b1;
              set_v[HALF_W*h + tcp_pkg::FL_CM] = 1'b1;
            end else begin
              cnt_d[h] = cnt_q[h] - 16'h0001;
            end
          end
        end else if (en[h] & (is_tim[h] | is_pwm[h])) begin
          // No prescaler: one step per clock
          cnt_d[h] = (cnt_q[h] == 16'h0) ? ilr_q[h] : cnt_q[h] - 16'h0001;
          if (is_tim[h] & hit[h]) begin
            cap_d[h] = cnt_q[h];
            set_v[HALF_W*h + tcp_pkg::FL_CE] = 1'b1;
          end
        end else if (en[h] & is_tmr[h] & ~stl[h]) begin
          if (ps_q[h] == 8'h00) begin
            ps_d[h] = pr_q[h];
            if (cnt_q[h] == 16'h0) begin
              cnt_d[h] = ilr_q[h];
              set_v[HALF_W*h + tcp_pkg::FL_TO] = 1'b1;
              en_clr[h] = (mr_q[h][1:0] == tcp_pkg::MR_ONE);
            end else begin
              cnt_d[h] = cnt_q[h] - 16'h0001;
            end
          end else begin
            ps_d[h] = ps_q[h] - 8'h01;
          end
        end
        // PWM level: set at start value, clear at match
        if (is_pwm[h] & en[h]) begin
          if (cnt_q[h] == ilr_q[h]) begin
            pwm_d[h] = 1'b1;
          end else if (cnt_q[h] == mat_q[h]) begin
            pwm_d[h] = 1'b0;
          end
        end
      end
    end
  end

  // Interval load writes, 32-bit wide in the joined modes
  always_comb begin
    ilr_wr[0] = wr & (wb_adr_i == tcp_pkg::OFS_AILR);
    ilr_wr[1] = wr & ((wb_adr_i == tcp_pkg::OFS_BILR) | (ilr_wr[0] & ~cfg16));
    ilr_nv[0] = 16'(bmask(i32, wb_dat_i, wb_sel_i));
    ilr_nv[1] = ilr_wr[0] ? 16'(bmask(i32, wb_dat_i, wb_sel_i) >> 16)
                          : 16'(bmask({16'h0, ilr_q[1]}, wb_dat_i, wb_sel_i));
  end

  // Counters, capture and prescale
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int h = 0; h < 2; h++) begin
        cnt_q[h] <= tcp_pkg::LOAD_RST;
        cap_q[h] <= tcp_pkg::LOAD_RST;
        ps_q[h]  <= 8'h00;
      end
    end else if (wr & (wb_adr_i == tcp_pkg::OFS_CFG)
                 & (wb_dat_i[2:0] == tcp_pkg::CFG_RTC) & wb_sel_i[0]) begin
      cnt_q[0] <= tcp_pkg::RTC_START[15:0];
      cnt_q[1] <= tcp_pkg::RTC_START[31:16];
    end else begin
      for (int h = 0; h < 2; h++) begin
        // A new load takes effect on the next cycle
        cnt_q[h] <= ilr_wr[h] ? ilr_nv[h] : cnt_d[h];
        cap_q[h] <= cap_d[h];
        ps_q[h]  <= ilr_wr[h] ? pr_q[h] : ps_d[h];
      end
    end
  end

  // PWM level and pin drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_q <= 2'h0;
      pin_q <= 2'h0;
      oe_q  <= 2'h0;
    end else begin
      pwm_q <= pwm_d;
      for (int h = 0; h < 2; h++) begin
        pin_q[h] <= pwm_d[h] ^ ctl_q[HALF_W*h + tcp_pkg::CTL_INV];
      end
      oe_q <= is_pwm;
    end
  end
  assign capture_compare_pin_o    = pin_q;
  assign capture_compare_pin_oe_o = oe_q;

  // ****************************************
  // Register file
  // ****************************************
  // Plain configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= 3'h0;
      imr_q <= 16'h0000;
      for (int h = 0; h < 2; h++) begin
        mr_q[h]  <= 4'h0;
        mat_q[h] <= tcp_pkg::LOAD_RST;
        pr_q[h]  <= 8'h00;
        ilr_q[h] <= tcp_pkg::LOAD_RST;
      end
    end else if (wr) begin
      for (int h = 0; h < 2; h++) begin
        if (ilr_wr[h]) begin
          ilr_q[h] <= ilr_nv[h];
        end
      end
      unique case (wb_adr_i)
        tcp_pkg::OFS_CFG:  cfg_q   <= 3'(bmask({29'h0, cfg_q}, wb_dat_i, wb_sel_i));
        tcp_pkg::OFS_AMR:  mr_q[0] <= 4'(bmask({28'h0, mr_q[0]}, wb_dat_i, wb_sel_i));
        tcp_pkg::OFS_BMR:  mr_q[1] <= 4'(bmask({28'h0, mr_q[1]}, wb_dat_i, wb_sel_i));
        tcp_pkg::OFS_IMR:  imr_q   <= 16'(bmask({16'h0, imr_q}, wb_dat_i, wb_sel_i));
        tcp_pkg::OFS_APR:  pr_q[0] <= 8'(bmask({24'h0, pr_q[0]}, wb_dat_i, wb_sel_i));
        tcp_pkg::OFS_BPR:  pr_q[1] <= 8'(bmask({24'h0, pr_q[1]}, wb_dat_i, wb_sel_i));
        tcp_pkg::OFS_AMAT: begin
          mat_q[0] <= 16'(bmask(m32, wb_dat_i, wb_sel_i));
          if (!cfg16) begin
            mat_q[1] <= 16'(bmask(m32, wb_dat_i, wb_sel_i) >> 16);
          end
        end
        tcp_pkg::OFS_BMAT: mat_q[1] <= 16'(bmask({16'h0, mat_q[1]}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // Control: software write wins over a self-clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= 16'h0000;
    end else if (wr & (wb_adr_i == tcp_pkg::OFS_CTL)) begin
      ctl_q <= 16'(bmask({16'h0, ctl_q}, wb_dat_i, wb_sel_i));
    end else begin
      ctl_q[tcp_pkg::CTL_EN]          <= en[0] & ~en_clr[0];
      ctl_q[HALF_W + tcp_pkg::CTL_EN] <= en[1] & ~en_clr[1];
    end
  end

  // Sticky status: a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ris_q <= 16'h0000;
    end else if (wr & (wb_adr_i == tcp_pkg::OFS_ICR)) begin
      ris_q <= (ris_q & ~16'(bmask(32'h0, wb_dat_i, wb_sel_i))) | set_v;
    end else begin
      ris_q <= ris_q | set_v;
    end
  end

  // Read multiplexer, unmapped reads give zero
  always_comb begin
    unique case (wb_adr_i)
      tcp_pkg::OFS_CFG:  rd_d = {29'h0, cfg_q};
      tcp_pkg::OFS_AMR:  rd_d = {28'h0, mr_q[0]};
      tcp_pkg::OFS_BMR:  rd_d = {28'h0, mr_q[1]};
      tcp_pkg::OFS_CTL:  rd_d = {16'h0, ctl_q};
      tcp_pkg::OFS_IMR:  rd_d = {16'h0, imr_q};
      tcp_pkg::OFS_RIS:  rd_d = {16'h0, ris_q};
      tcp_pkg::OFS_MIS:  rd_d = {16'h0, ris_q & imr_q};
      tcp_pkg::OFS_AILR: rd_d = cfg16 ? {16'h0, ilr_q[0]} : i32;
      tcp_pkg::OFS_BILR: rd_d = {16'h0, ilr_q[1]};
      tcp_pkg::OFS_AMAT: rd_d = cfg16 ? {16'h0, mat_q[0]} : m32;
      tcp_pkg::OFS_BMAT: rd_d = {16'h0, mat_q[1]};
      tcp_pkg::OFS_APR:  rd_d = {24'h0, pr_q[0]};
      tcp_pkg::OFS_BPR:  rd_d = {24'h0, pr_q[1]};
      tcp_pkg::OFS_AR:   rd_d = !cfg16 ? c32 : {16'h0, is_tim[0] ? cap_q[0] : cnt_q[0]};
      tcp_pkg::OFS_BR:   rd_d = {16'h0, is_tim[1] ? cap_q[1] : cnt_q[1]};
      default:           rd_d = 32'h0;
    endcase
  end

  // One-wait-state acknowledge, data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      if (wb_cyc_i & wb_stb_i & ~ack_q) begin
        dat_q <= rd_d;
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_cnt_dec;
    is_cnt[0] & en[0] & hit[0] & (dec0 != mat_q[0]) & ~wr |=> cnt_q[0] == $past(dec0);
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("edge did not decrement");
  property p_cnt_match;
    is_cnt[0] & en[0] & hit[0] & (dec0 == mat_q[0]) & ~wr
      |=> ris_q[tcp_pkg::FL_CM] && !en[0] && cnt_q[0] == ilr_q[0];
  endproperty
  a_cnt_match: assert property (p_cnt_match) else $error("match not handled");
  property p_cnt_idle;
    is_cnt[0] & ~en[0] & ~wr |=> $stable(cnt_q[0]);
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("edge counted while stopped");
  property p_capture;
    is_tim[0] & en[0] & hit[0] |=> cap_q[0] == $past(cnt_q[0]) && ris_q[tcp_pkg::FL_CE];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");
  property p_cap_hold;
    ~(is_tim[0] & en[0] & hit[0]) |=> $stable(cap_q[0]);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture changed");
  property p_tim_step;
    is_tim[0] & en[0] & ~ilr_wr[0] & (cnt_q[0] != 16'h0) |=> cnt_q[0] == $past(dec0);
  endproperty
  a_tim_step: assert property (p_tim_step) else $error("edge time step wrong");
  property p_tim_reload;
    (is_tim[0] | is_pwm[0]) & en[0] & ~wr & (cnt_q[0] == 16'h0) |=> cnt_q[0] == ilr_q[0];
  endproperty
  a_tim_reload: assert property (p_tim_reload) else $error("no reload at zero");
  property p_pwm_quiet;
    is_pwm[0] |-> set_v[7:0] == 8'h00;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("flag in PWM mode");
  property p_pwm_high;
    is_pwm[0] & en[0] & (cnt_q[0] == ilr_q[0])
      |=> pin_q[0] == ~ctl_q[tcp_pkg::CTL_INV] ##1 oe_q[0];
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("PWM start level wrong");
  property p_oneshot;
    is_tmr[0] & en[0] & ~stl[0] & ~wr & (ps_q[0] == 8'h00) & (cnt_q[0] == 16'h0)
      & (mr_q[0][1:0] == tcp_pkg::MR_ONE) |=> !en[0] && ris_q[tcp_pkg::FL_TO];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");
  property p_rtc_wrap;
    (cfg_q == tcp_pkg::CFG_RTC) & en[0] & (~stl[0] | ctl_q[tcp_pkg::CTL_RTCO]) & sec_tick
      & (c32 == m32) & ~wr
      |=> c32 == 32'h0 && ris_q[tcp_pkg::FL_RTC];
  endproperty
  a_rtc_wrap: assert property (p_rtc_wrap) else $error("clock mode wrap wrong");
  property p_clear;
    wr & (wb_adr_i == tcp_pkg::OFS_ICR) & wb_sel_i[0] & wb_dat_i[tcp_pkg::FL_TO]
      & ~set_v[tcp_pkg::FL_TO] |=> !ris_q[tcp_pkg::FL_TO];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule

// file: bench/tcp_pin_source.sv
// Partner model: signal source driving the capture/compare pins.
// Assumes clk_i is the system clock; levels stand still unless run_i is high.
`timescale 1ns/1ps
module tcp_pin_source (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       run_i,
  // Pin levels towards the unit
  output logic      [1:0] pin_o
);
  // ****************************************
  // Edge generator
  // ****************************************
  logic [1:0] gap_q = 2'h0;
  initial pin_o = 2'h0;
  // Toggle both pins every third clock, so each level holds three clocks
  always @(posedge clk_i) begin
    if (run_i) begin
      gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      if (gap_q == 2'h2) begin
        pin_o <= ~pin_o;
      end
    end
  end
endmodule

// file: bench/tb_top.sv
// Testbench: register-level tests of the timer capture and PWM unit.
// Assumes the unit answers classic Wishbone and a pin source as partner.
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Clock, reset, bus and pins
  // ****************************************
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [1:0]  pin_in, pin_out, pin_oe, src;
  logic        run = 1'b0;
  logic [31:0] q, x;
  int          miscompares = 0;
  int          num_checks = 0;
  int          n;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Wire level: unit drives while in PWM mode, source otherwise
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & src);
  tcp_timer_capture_pwm_unit #(.RTC_DIV(4)) tcp_timer_capture_pwm_unit_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .capture_compare_pin_i(pin_in),
    .capture_compare_pin_o(pin_out), .capture_compare_pin_oe_o(pin_oe));
  tcp_pin_source tcp_pin_source_i (.clk_i(clk_i), .run_i(run), .pin_o(src));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; holds until ack is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // Length of the next high run on half A pin
  task automatic high_run(output int len);
    int k;
    k = 0;
    while (pin_out[0] !== 1'b0 && k < 60) begin @(posedge clk_i); k++; end
    while (pin_out[0] !== 1'b1 && k < 60) begin @(posedge clk_i); k++; end
    len = 0;
    while (pin_out[0] === 1'b1 && len < 60) begin @(posedge clk_i); len++; end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #(20 * 5000);
    miscompares++;
    print_verdict();
  end
  initial begin
    idle(3);
    rst_i <= 1'b0;
    rd(8'h28); check(q, 32'hffffffff);
    rd(8'h30); check(q, 32'hffffffff);
    wr(8'h44, 32'h5); rd(8'h44); check(q, 32'h0);
    $display("test reset done");
    // Edge count, both edges, 10 down to 6
    wr(8'h00, 32'h4); wr(8'h04, 32'h3); wr(8'h28, 32'ha);
    wr(8'h30, 32'h6); wr(8'h18, 32'h2); wr(8'h0c, 32'h8); wr(8'h0c, 32'h9);
    run <= 1'b1; idle(30); run <= 1'b0; idle(6);
    rd(8'h1c); check(q, 32'h2);
    rd(8'h20); check(q, 32'h2);
    rd(8'h0c); check(q, 32'h8);
    rd(8'h48); check(q, 32'ha);
    wr(8'h24, 32'hff); rd(8'h1c); check(q, 32'h0);
    $display("test edge count done");
    // Edge time, rising edges
    wr(8'h0c, 32'h0); wr(8'h04, 32'h7); wr(8'h28, 32'hffff);
    wr(8'h18, 32'h4); wr(8'h0c, 32'h1);
    run <= 1'b1; idle(4); run <= 1'b0; idle(6);
    rd(8'h1c); check(q, 32'h4);
    rd(8'h48); x = q; idle(10);
    rd(8'h48); check(q, x);
    $display("test edge time done");
    // PWM: period 10 counts, match 3
    wr(8'h0c, 32'h0); wr(8'h04, 32'ha); wr(8'h28, 32'h9);
    wr(8'h30, 32'h3); wr(8'h24, 32'hff); wr(8'h0c, 32'h1);
    idle(4); check({31'h0, pin_oe[0]}, 32'h1);
    high_run(n); check(n, 32'h6);
    rd(8'h1c); check(q, 32'h0);
    wr(8'h0c, 32'h0); wr(8'h0c, 32'h41);
    idle(4); high_run(n); check(n, 32'h4);
    $display("test pwm done");
    // One-shot then periodic, load 5
    wr(8'h0c, 32'h0); wr(8'h04, 32'h1); wr(8'h38, 32'h0);
    wr(8'h28, 32'h5); wr(8'h24, 32'hff); wr(8'h0c, 32'h1); idle(30);
    rd(8'h1c); check(q, 32'h1);
    rd(8'h0c); check(q, 32'h0);
    wr(8'h04, 32'h2); wr(8'h0c, 32'h1); idle(30);
    rd(8'h0c); check(q, 32'h1);
    $display("test timer modes done");
    // Clock mode: start 1, match 3, one tick per four pin rises
    wr(8'h0c, 32'h0); wr(8'h00, 32'h1); wr(8'h30, 32'h3);
    wr(8'h24, 32'hff); wr(8'h0c, 32'h1);
    run <= 1'b1; idle(117); run <= 1'b0; idle(6);
    rd(8'h1c); check(q, 32'h8);
    rd(8'h0c); check(q, 32'h1);
    rd(8'h48); check(q, 32'h1);
    $display("test clock mode done");
    // Joined 32-bit one-shot, load 4
    wr(8'h0c, 32'h0); wr(8'h00, 32'h0); wr(8'h04, 32'h1);
    wr(8'h28, 32'h4); wr(8'h24, 32'hff); wr(8'h0c, 32'h1); idle(20);
    rd(8'h1c); check(q, 32'h1);
    rd(8'h48); check(q, 32'h4);
    rd(8'h0c); check(q, 32'h0);
    $display("test 32-bit timer done");
    print_verdict();
  end
endmodule
